// file: alu_sequencer.sv
// microsequencer end: register port, microword checks and issue
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module alu_sequencer
  import alu_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  alu_link_if.sequencer link,
  input wire logic [3:0] i_address,
  input wire logic [15:0] i_write_data,
  input wire logic i_write,
  input wire logic i_read,
  output logic [15:0] o_read_data,
  output logic o_busy
);
  typedef enum logic [1:0] {idle, issue, wait_done} phase_type;

  typedef struct packed {
    phase_type phase;
    microword_type mw;
    logic [15:0] control;
    logic [15:0] result;
    flags_type flags;
    logic test;
    logic error;
    logic busy;
    logic [15:0] read_data;
  } state_type;

  state_type state_reg;
  state_type state_next;
  logic b_is_fixed;
  logic illegal;

  always_comb begin
    b_is_fixed = (state_reg.mw.b_src == literal_source) ||
                 (state_reg.mw.b_src == masked_instruction_source);
    // RL6 forbidden functions with literal
    illegal = b_is_fixed && ((state_reg.mw.func == increment_b) ||
      (state_reg.mw.func == subtract_ab) || (state_reg.mw.func == complement_b) ||
      (state_reg.mw.func == twos_complement_b));
    // RL9 no general destination
    if (b_is_fixed && (state_reg.mw.dest == dest_general)) begin
      illegal = 1'b1;
    end
  end

  always_comb begin
    state_next = state_reg;
    state_next.read_data = RESET_WORD;
    if (i_write) begin
      unique case (i_address)
        ADDR_CONTROL: begin
          state_next.control = i_write_data;
          state_next.mw.func = alu_func_type'(i_write_data[CTRL_FUNC_LSB +: 5]);
          state_next.mw.a_src = a_src_type'(i_write_data[CTRL_A_SRC_LSB +: 2]);
          state_next.mw.b_src = b_src_type'(i_write_data[CTRL_B_SRC_LSB +: 2]);
          state_next.mw.dest = dest_type'(i_write_data[CTRL_DEST_LSB +: 2]);
          state_next.mw.status_set = status_set_type'(i_write_data[CTRL_SET_LSB +: 2]);
          state_next.mw.test_sel = test_sel_type'(i_write_data[CTRL_TEST_LSB]);
        end
        // RL10 shared a and destination index
        ADDR_INDEX: begin
          state_next.mw.a_index = i_write_data[INDEX_A_LSB +: INDEX_WIDTH];
          state_next.mw.b_index = i_write_data[INDEX_B_LSB +: INDEX_WIDTH];
        end
        // RL7 literal field kept apart
        ADDR_VALUE: state_next.mw.value = i_write_data;
        ADDR_ISSUE: begin
          if (state_reg.phase == idle) begin
            state_next.error = illegal;
            if (!illegal) begin
              state_next.phase = issue;
            end
          end
        end
        default: state_next.phase = state_reg.phase;
      endcase
    end
    if (i_read) begin
      unique case (i_address)
        ADDR_CONTROL: state_next.read_data = state_reg.control;
        ADDR_INDEX: state_next.read_data = {8'h00, state_reg.mw.b_index, state_reg.mw.a_index};
        ADDR_VALUE: state_next.read_data = state_reg.mw.value;
        ADDR_STATUS: begin
          state_next.read_data[STATUS_BUSY_BIT] = (state_reg.phase != idle);
          state_next.read_data[STATUS_ERROR_BIT] = state_reg.error;
          state_next.read_data[STATUS_TEST_BIT] = state_reg.test;
          state_next.read_data[STATUS_FLAGS_LSB +: 6] = state_reg.flags;
        end
        ADDR_RESULT: state_next.read_data = state_reg.result;
        default: state_next.read_data = RESET_WORD;
      endcase
    end
    unique case (state_reg.phase)
      idle: state_next.phase = state_next.phase;
      issue: state_next.phase = wait_done;
      wait_done: begin
        if (link.done) begin
          state_next.phase = idle;
          state_next.result = link.result;
          state_next.flags = link.flags;
          state_next.test = link.test;
        end
      end
      default: state_next.phase = idle;
    endcase
    // busy flag registered beside the phase
    state_next.busy = (state_next.phase != idle);
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign link.issue_valid = (state_reg.phase == issue);
  assign link.microword = state_reg.mw;
  assign o_read_data = state_reg.read_data;
  assign o_busy = state_reg.busy;
endmodule // alu_sequencer

// file: alu_pkg.sv
// shared constants and types for the microword alu datapath
// Summary of operation
// RL1 - functions give zeros, ones, a, b
// RL2 - increment a; increment b is (a or b)+1
// RL3 - decrement a; decrement b is a plus b
// RL4 - add, subtract b from a, double a
// RL5 - operand right byte moved left, zero fill
// RL6 - no b-modifying functions with literal or mask
// RL7 - literal and mask field must not clash
// RL8 - destination: sixteen general or special register
// RL9 - no general destination with literal or mask
// RL10 - input a and destination share one index
// RL11 - status set: shift, overflow or result flags
// RL12 - test selects overflow or io sense response
// RL13 - literal source is sixteen-bit microword constant
// RL14 - mask source is instruction and microword mask
// RL15 - and, or, xor, complements, twos complement b
// RL16 - sixteen-bit results wrap, carry feeds flag
package alu_pkg;
  localparam int DATA_WIDTH = 16;
  localparam int REG_COUNT = 16;
  localparam int INDEX_WIDTH = 4;
  localparam int BYTE_WIDTH = 8;
  localparam logic [15:0] ALL_ZEROS = 16'h0000;
  localparam logic [15:0] ALL_ONES = 16'hFFFF;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // controller register addresses
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_INDEX = 4'h1;
  localparam logic [3:0] ADDR_VALUE = 4'h2;
  localparam logic [3:0] ADDR_ISSUE = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_RESULT = 4'h5;

  // control and index register field positions
  localparam int CTRL_FUNC_LSB = 0;
  localparam int CTRL_A_SRC_LSB = 5;
  localparam int CTRL_B_SRC_LSB = 7;
  localparam int CTRL_DEST_LSB = 9;
  localparam int CTRL_SET_LSB = 11;
  localparam int CTRL_TEST_LSB = 13;
  localparam int INDEX_A_LSB = 0;
  localparam int INDEX_B_LSB = 4;

  // status register field positions
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_ERROR_BIT = 1;
  localparam int STATUS_TEST_BIT = 2;
  localparam int STATUS_FLAGS_LSB = 8;

  localparam logic [15:0] RESET_WORD = 16'h0000;

  typedef enum logic [4:0] {
    zero_word, ones_word, pass_input_a, pass_input_b, increment_a, increment_b,
    decrement_a, decrement_b, add_ab, subtract_ab, double_a, and_ab, or_ab,
    exclusive_or, complement_a, complement_b, twos_complement_b
  } alu_func_type;

  typedef enum logic [1:0] {a_general, a_zero, a_ones, a_spare} a_src_type;
  typedef enum logic [1:0] {
    b_general, literal_source, masked_instruction_source, left_byte_zero_fill
  } b_src_type;
  typedef enum logic [1:0] {dest_none, dest_general, dest_special, dest_spare} dest_type;
  typedef enum logic [1:0] {set_none, set_shift, set_overflow, set_result} status_set_type;
  typedef enum logic {test_overflow, test_io_sense} test_sel_type;

  typedef struct packed {
    alu_func_type func;
    a_src_type a_src;
    b_src_type b_src;
    dest_type dest;
    status_set_type status_set;
    test_sel_type test_sel;
    logic [3:0] a_index;
    logic [3:0] b_index;
    logic [15:0] value;
  } microword_type;

  typedef struct packed {
    logic shift_flag;
    logic overflow_flag;
    logic result_ones_flag;
    logic result_sign_flag;
    logic result_carry_flag;
    logic result_zeros_flag;
  } flags_type;
endpackage

// file: alu_link_if.sv
// link between microsequencer end and alu datapath end
`timescale 1ns/1ps
interface alu_link_if
  import alu_pkg::*;
(
  input wire logic i_clock
);
  logic issue_valid;
  microword_type microword;
  logic done;
  logic [15:0] result;
  flags_type flags;
  logic test;

  modport sequencer (
    output issue_valid,
    output microword,
    input done,
    input result,
    input flags,
    input test
  );

  modport datapath (
    input issue_valid,
    input microword,
    output done,
    output result,
    output flags,
    output test
  );
endinterface

// file: alu_function.sv
// combinational sixteen-bit function unit
`timescale 1ns/1ps
module alu_function
  import alu_pkg::*;
#(
  parameter int WIDTH = DATA_WIDTH
) (
  input wire alu_func_type i_func,
  input wire logic [WIDTH-1:0] i_a,
  input wire logic [WIDTH-1:0] i_b,
  output logic [WIDTH-1:0] o_result,
  output logic o_carry
);
  if (WIDTH < 2) begin : g_bad_width
    $error("alu width too small");
  end

  logic [WIDTH:0] sum;
  logic [WIDTH:0] ext_a;
  logic [WIDTH:0] ext_b;
  logic [WIDTH:0] one;

  always_comb begin
    ext_a = {1'b0, i_a};
    ext_b = {1'b0, i_b};
    one = (WIDTH+1)'(1);
    sum = '0;
    unique case (i_func)
      // RL1 constants and transfers
      zero_word: sum = '0;
      ones_word: sum = {1'b0, {WIDTH{1'b1}}};
      pass_input_a: sum = ext_a;
      pass_input_b: sum = ext_b;
      // RL2 increment forms
      increment_a: sum = ext_a + one;
      increment_b: sum = {1'b0, i_a | i_b} + one;
      // RL3 decrement forms
      decrement_a: sum = ext_a + {1'b0, {WIDTH{1'b1}}};
      decrement_b: sum = ext_a + ext_b;
      // RL4 add subtract double
      add_ab: sum = ext_a + ext_b;
      subtract_ab: sum = ext_a + {1'b0, ~i_b} + one;
      double_a: sum = ext_a + ext_a;
      // RL15 logical and complements
      and_ab: sum = {1'b0, i_a & i_b};
      or_ab: sum = {1'b0, i_a | i_b};
      exclusive_or: sum = {1'b0, i_a ^ i_b};
      complement_a: sum = {1'b0, ~i_a};
      complement_b: sum = {1'b0, ~i_b};
      twos_complement_b: sum = {1'b0, ~i_b} + one;
      default: sum = '0;
    endcase
    // RL16 wrap and carry
    o_result = sum[WIDTH-1:0];
    o_carry = sum[WIDTH];
  end
endmodule // alu_function

// file: alu_datapath.sv
// alu datapath end: register file, operand select, flags, test
`timescale 1ns/1ps
module alu_datapath
  import alu_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  alu_link_if.datapath link,
  input wire logic [15:0] i_instruction,
  input wire logic i_io_sense,
  output logic [15:0] o_result,
  output flags_type o_flags,
  output logic o_test,
  output logic [15:0] o_operand
);
  typedef struct packed {
    logic [REG_COUNT-1:0][DATA_WIDTH-1:0] general;
    logic [DATA_WIDTH-1:0] operand;
    logic [DATA_WIDTH-1:0] result;
    flags_type flags;
    logic test;
    logic done;
    logic io_sync1;
    logic io_sync2;
  } state_type;

  state_type state_reg;
  state_type state_next;
  microword_type mw;
  logic [DATA_WIDTH-1:0] a_operand;
  logic [DATA_WIDTH-1:0] b_operand;
  logic [DATA_WIDTH-1:0] alu_result;
  logic alu_carry;

  assign mw = link.microword;

  always_comb begin
    unique case (mw.a_src)
      // RL10 one index for input a
      a_general: a_operand = state_reg.general[mw.a_index];
      a_zero: a_operand = ALL_ZEROS;
      a_ones: a_operand = ALL_ONES;
      default: a_operand = ALL_ZEROS;
    endcase
    unique case (mw.b_src)
      b_general: b_operand = state_reg.general[mw.b_index];
      // RL13 microword literal constant
      literal_source: b_operand = mw.value;
      // RL14 masked instruction register
      masked_instruction_source: b_operand = i_instruction & mw.value;
      // RL5 right byte to left
      left_byte_zero_fill: b_operand = {state_reg.operand[BYTE_WIDTH-1:0], ZERO_BYTE};
    endcase
  end

  alu_function #(
    .WIDTH(DATA_WIDTH)
  ) u_function (
    .i_func(mw.func),
    .i_a(a_operand),
    .i_b(b_operand),
    .o_result(alu_result),
    .o_carry(alu_carry)
  );

  always_comb begin
    state_next = state_reg;
    // io sense two-stage synchroniser
    state_next.io_sync1 = i_io_sense;
    state_next.io_sync2 = state_reg.io_sync1;
    state_next.done = 1'b0;
    if (link.issue_valid) begin
      state_next.done = 1'b1;
      state_next.result = alu_result;
      // RL8 destination select
      unique case (mw.dest)
        dest_general: state_next.general[mw.a_index] = alu_result;
        dest_special: state_next.operand = alu_result;
        default: state_next.result = alu_result;
      endcase
      // RL11 status set select
      unique case (mw.status_set)
        set_shift: state_next.flags.shift_flag = 1'b1;
        set_overflow: state_next.flags.overflow_flag = 1'b1;
        set_result: begin
          state_next.flags.result_ones_flag = (alu_result == ALL_ONES);
          state_next.flags.result_sign_flag = alu_result[DATA_WIDTH-1];
          // RL16 carry into flag
          state_next.flags.result_carry_flag = alu_carry;
          state_next.flags.result_zeros_flag = (alu_result == ALL_ZEROS);
        end
        default: state_next.flags = state_reg.flags;
      endcase
      // RL12 test condition select
      unique case (mw.test_sel)
        test_overflow: state_next.test = state_reg.flags.overflow_flag;
        test_io_sense: state_next.test = state_reg.io_sync2;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign link.done = state_reg.done;
  assign link.result = state_reg.result;
  assign link.flags = state_reg.flags;
  assign link.test = state_reg.test;
  assign o_result = state_reg.result;
  assign o_flags = state_reg.flags;
  assign o_test = state_reg.test;
  assign o_operand = state_reg.operand;
endmodule // alu_datapath

// file: alu_link_properties.sv
// concurrent checks on the sequencer to datapath link
`timescale 1ns/1ps
module alu_link_checker
  import alu_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic issue_valid,
  input wire microword_type microword,
  input wire logic done,
  input wire logic [15:0] result,
  input wire flags_type flags,
  input wire logic test
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  sequence s_go(f);
    issue_valid && microword.func == f;
  endsequence
  sequence s_lit(f, a);
    s_go(f) ##0 (microword.b_src == literal_source && microword.a_src == a);
  endsequence
  a_done_pulse: assert property (issue_valid |=> done ##1 !done)
    else $error("done not a single cycle after issue");
  a_done_cause: assert property (done |-> $past(issue_valid))
    else $error("done without an issue");
  a_zero_word: assert property (s_go(zero_word) |=> result == 16'h0000)
    else $error("zero word not zero");
  a_ones_word: assert property (s_go(ones_word) |=> result == 16'hFFFF)
    else $error("ones word not all ones");
  a_inc_zero: assert property (s_lit(increment_a, a_zero) |=> result == 16'h0001)
    else $error("increment of zero not one");
  a_dec_b_ones: assert property (s_lit(decrement_b, a_ones) |=>
    result == $past(microword.value) - 16'h0001) else $error("decrement b wrong");
  a_double_ones: assert property (s_lit(double_a, a_ones) |=> result == 16'hFFFE)
    else $error("double of all ones wrong");
  a_pass_literal: assert property (s_lit(pass_input_b, a_zero) |=>
    result == $past(microword.value)) else $error("literal not passed");
  a_result_flags: assert property (issue_valid && microword.status_set == set_result |=>
    flags.result_zeros_flag == (result == 16'h0000) && flags.result_sign_flag == result[15]
    && flags.result_ones_flag == (result == 16'hFFFF)) else $error("result flags wrong");
  a_shift_kept: assert property (flags.shift_flag |=> flags.shift_flag)
    else $error("shift flag dropped");
  a_shift_set: assert property (issue_valid && microword.status_set == set_shift |=>
    flags.shift_flag) else $error("shift flag not set");
  a_test_ovf: assert property (issue_valid && microword.test_sel == test_overflow |=>
    test == $past(flags.overflow_flag)) else $error("overflow test wrong");
endmodule // alu_link_checker

// file: tb_top.sv
// self-checking bench joining sequencer and datapath ends
`timescale 1ns/1ps
module tb_top
  import alu_pkg::*;
;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic [3:0] i_address = 4'h0;
  logic [15:0] i_write_data = 16'h0000;
  logic i_write = 1'b0;
  logic i_read = 1'b0;
  logic [15:0] i_instruction = 16'h0000;
  logic i_io_sense = 1'b0;
  logic [15:0] o_read_data, o_result, o_operand, prev;
  logic o_busy, o_test;
  logic [16:0] m;
  flags_type o_flags;
  int error_cnt = 0;
  int n_compared = 0;
  alu_func_type lit_ops [7] = '{pass_input_b, increment_a, decrement_a, decrement_b, add_ab,
    double_a, exclusive_or};
  alu_func_type bad_ops [4] = '{increment_b, subtract_ab, complement_b, twos_complement_b};
  always #2.5 i_clock = ~i_clock;
  alu_link_if link (.i_clock(i_clock));
  alu_sequencer u_alu_sequencer (.i_clock(i_clock), .i_reset(i_reset), .link(link.sequencer),
    .i_address(i_address), .i_write_data(i_write_data), .i_write(i_write), .i_read(i_read),
    .o_read_data(o_read_data), .o_busy(o_busy));
  alu_datapath u_alu_datapath (.i_clock(i_clock), .i_reset(i_reset), .link(link.datapath),
    .i_instruction(i_instruction), .i_io_sense(i_io_sense), .o_result(o_result),
    .o_flags(o_flags), .o_test(o_test), .o_operand(o_operand));
  alu_link_checker u_alu_link_checker (.i_clock(i_clock), .i_reset(i_reset),
    .issue_valid(link.issue_valid), .microword(link.microword), .done(link.done),
    .result(link.result), .flags(link.flags), .test(link.test));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clock);
    i_address <= a;
    i_write_data <= d;
    i_write <= 1'b1;
    @(posedge i_clock);
    i_write <= 1'b0;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [15:0] exp, input string what);
    @(posedge i_clock);
    i_address <= a;
    i_read <= 1'b1;
    @(posedge i_clock);
    i_read <= 1'b0;
    #1;
    chk(what, exp, o_read_data);
  endtask
  task automatic issue(input alu_func_type f, input a_src_type a, input b_src_type b,
      input dest_type d, input status_set_type s, input test_sel_type t,
      input logic [7:0] idx, input logic [15:0] v);
    int n;
    wr(ADDR_CONTROL, {2'b00, t, s, d, b, a, f});
    wr(ADDR_INDEX, {8'h00, idx});
    wr(ADDR_VALUE, v);
    wr(ADDR_ISSUE, 16'h0000);
    #1;
    n = 0;
    while (o_busy !== 1'b0 && n < 20) begin
      @(posedge i_clock);
      #1;
      n++;
    end
    if (n == 20) chk("busy", 16'h0000, 16'h0001);
  endtask
  function automatic logic [16:0] model(input logic [4:0] f, input logic [15:0] a,
      input logic [15:0] b);
    case (f)
      5'h00: return 17'h00000;
      5'h01: return 17'h0FFFF;
      5'h02: return {1'b0, a};
      5'h03: return {1'b0, b};
      5'h04: return {1'b0, a} + 17'h00001;
      5'h05: return {1'b0, a | b} + 17'h00001;
      5'h06: return {a != 16'h0000, a - 16'h0001};
      5'h07, 5'h08: return {1'b0, a} + {1'b0, b};
      5'h09: return {a >= b, a - b};
      5'h0A: return {1'b0, a} + {1'b0, a};
      5'h0B: return {1'b0, a & b};
      5'h0C: return {1'b0, a | b};
      5'h0D: return {1'b0, a ^ b};
      5'h0E: return {1'b0, ~a};
      5'h0F: return {1'b0, ~b};
      default: return {b == 16'h0000, 16'h0000 - b};
    endcase
  endfunction
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge i_clock);
    i_reset <= 1'b0;
    rdchk(ADDR_STATUS, 16'h0000, "status after reset");
    rdchk(ADDR_RESULT, 16'h0000, "result after reset");
    wr(4'hF, 16'hFFFF);
    rdchk(4'hF, 16'h0000, "unmapped");
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      issue(pass_input_b, a_zero, literal_source, dest_special, set_none, test_overflow, 8'h00,
        {8'h00, 4'(i), 4'(15 - i)});
      chk("operand", {8'h00, 4'(i), 4'(15 - i)}, o_operand);
      issue(pass_input_b, a_zero, left_byte_zero_fill, dest_general, set_none, test_overflow,
        8'(i), 16'h0000);
    end
    for (int i = 0; i < 16; i++) begin
      issue(pass_input_a, a_general, b_general, dest_none, set_none, test_overflow, 8'(i),
        16'h0000);
      chk("general", {4'(i), 4'(15 - i), 8'h00}, o_result);
    end
    $display("test registers done");
    for (int f = 0; f < 17; f++) begin
      issue(alu_func_type'(f), a_general, b_general, dest_none, set_result, test_overflow,
        8'hCA, 16'h0000);
      m = model(5'(f), 16'hA500, 16'hC300);
      rdchk(ADDR_RESULT, m[15:0], "function result");
      rdchk(ADDR_STATUS, {4'h0, m[15:0] == 16'hFFFF, m[15], m[16], m[15:0] == 16'h0000,
        8'h00}, "result flags");
    end
    $display("test functions done");
    foreach (lit_ops[k]) begin
      for (int s = 1; s < 3; s++) begin
        issue(lit_ops[k], a_src_type'(s), literal_source, dest_none, set_result, test_overflow,
          8'h00, 16'h8001);
        m = model(lit_ops[k], (s == 2) ? 16'hFFFF : 16'h0000, 16'h8001);
        chk("literal", m[15:0], o_result);
      end
    end
    @(posedge i_clock);
    i_instruction <= 16'h5A5A;
    issue(pass_input_b, a_zero, masked_instruction_source, dest_none, set_none, test_overflow,
      8'h00, 16'h0FF0);
    chk("mask", 16'h0A50, o_result);
    $display("test literal done");
    prev = o_result;
    foreach (bad_ops[k]) begin
      issue(bad_ops[k], a_zero, literal_source, dest_none, set_none, test_overflow, 8'h00,
        16'h0001);
      rdchk(ADDR_STATUS, 16'h0002, "refused status");
      chk("refused result", prev, o_result);
    end
    issue(pass_input_b, a_zero, literal_source, dest_general, set_none, test_overflow, 8'h03,
      16'h0001);
    rdchk(ADDR_STATUS, 16'h0002, "refused general");
    chk("refused kept", prev, o_result);
    issue(zero_word, a_zero, b_general, dest_none, set_none, test_overflow, 8'h00,
      16'h0000);
    rdchk(ADDR_STATUS, 16'h0000, "error cleared");
    $display("test refusal done");
    issue(zero_word, a_zero, b_general, dest_none, set_shift, test_overflow, 8'h00,
      16'h0000);
    issue(ones_word, a_zero, b_general, dest_none, set_overflow, test_overflow, 8'h00,
      16'h0000);
    issue(zero_word, a_zero, b_general, dest_none, set_none, test_overflow, 8'h00,
      16'h0000);
    rdchk(ADDR_STATUS, 16'h3004, "shift overflow test");
    chk("datapath flags", 16'h0030, 16'(o_flags));
    @(posedge i_clock);
    i_io_sense <= 1'b1;
    issue(zero_word, a_zero, b_general, dest_none, set_none, test_io_sense, 8'h00,
      16'h0000);
    chk("io sense high", 16'h0001, 16'(o_test));
    @(posedge i_clock);
    i_io_sense <= 1'b0;
    issue(zero_word, a_zero, b_general, dest_none, set_none, test_io_sense, 8'h00,
      16'h0000);
    chk("io sense low", 16'h0000, 16'(o_test));
    $display("test status done");
    stop_test();
  end
endmodule // tb_top
